// ===== inc/rmsw_pkg.sv
package rmsw_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFFS   = 8'h00;
  localparam logic [7:0] STATUS_OFFS = 8'h04;
  localparam logic [7:0] SLEW_OFFS   = 8'h08;

  // control field positions
  localparam int MODE_LSB   = 0;
  localparam int POLICY_LSB = 2;
  localparam int SEL_BIT    = 4;

  // status field positions
  localparam int ST_LOCK     = 0;
  localparam int ST_LOSC     = 1;
  localparam int ST_REFA     = 2;
  localparam int ST_REFB     = 3;
  localparam int ST_HOLD     = 4;
  localparam int ST_ACTIVE   = 5;
  localparam int ST_SLEWING  = 6;

  // reset values
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [7:0] SLEW_RST = 8'h10;

  // missing-edge threshold in feedback edges
  localparam logic [1:0] MISS_EDGES = 2'h3;

  // least gap between two phase extension steps
  localparam int CLK_MHZ       = 100;
  localparam int SLEW_GAP_NS   = 1000;
  localparam int SLEW_GAP_CYC  = (SLEW_GAP_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    MODE_SYNTH = 2'h0,
    MODE_HBW   = 2'h1,
    MODE_LBW   = 2'h2,
    MODE_RSVD  = 2'h3
  } rmsw_mode_t;

  typedef enum logic [1:0] {
    POL_MAN_PIN = 2'h0,
    POL_MAN_REG = 2'h1,
    POL_AUTO_REV = 2'h2,
    POL_AUTO_NREV = 2'h3
  } rmsw_policy_t;
endpackage

// ===== src/rmsw_core.sv
`timescale 1ns/100ps
module rmsw_core (
  input  wire logic        pclk,            // bus and monitor clock
  input  wire logic        presetn,         // async reset, active low
  input  wire logic        psel,            // apb select
  input  wire logic        penable,         // apb enable
  input  wire logic        pwrite,          // apb direction
  input  wire logic [7:0]  paddr,           // apb byte address
  input  wire logic [31:0] pwdata,          // apb write data
  output logic      [31:0] prdata,          // apb read data
  output logic             pready,          // apb ready
  output logic             pslverr,         // apb error
  input  wire logic        local_osc_in,    // local oscillator pin
  input  wire logic        ref_in_a,        // pre-divided reference a
  input  wire logic        ref_in_b,        // pre-divided reference b
  input  wire logic        upper_fb_in,     // upper loop feedback
  input  wire logic        lower_fb_in,     // lower loop feedback
  input  wire logic        freq_lock_in,    // frequency lock from loop
  input  wire logic        ref_sel_pin,     // external select pin
  output logic             lock_out,        // lock pin
  output logic             holdover_out,    // holdover pin
  output logic             active_ref,      // 0 = ref a, 1 = ref b
  output logic             local_osc_fail_flag, // local oscillator alarm
  output logic             ref_a_fail_flag, // reference a alarm
  output logic             ref_b_fail_flag, // reference b alarm
  output logic             phase_extend,    // one-cycle period stretch
  output logic             phase_freeze     // no phase adjustment
);
  localparam int NSYNC = 7;

  typedef enum {S_IDLE, S_MANUAL, S_ACQUIRE, S_RUN, S_HOLD} rmsw_state_t;

  // input synchronisers: stage one is read only by stage two
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic [NSYNC-1:0] sync3;
  logic [NSYNC-1:0] pins;
  logic [NSYNC-1:0] rise;

  assign pins = {ref_sel_pin, freq_lock_in, lower_fb_in, upper_fb_in, ref_in_b, ref_in_a, local_osc_in};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
        end else begin
          sync1[gi] <= pins[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
        end
      end
      assign rise[gi] = sync2[gi] & ~sync3[gi];
    end
  endgenerate

  logic osc_edge, refa_edge, refb_edge, up_edge, lo_edge, lock_s, pin_sel;
  assign osc_edge  = rise[0];
  assign refa_edge = rise[1];
  assign refb_edge = rise[2];
  assign up_edge   = rise[3];
  assign lo_edge   = rise[4];
  assign lock_s    = sync2[5];
  assign pin_sel   = sync2[6];

  // registers
  logic [4:0] ctrl;
  logic [7:0] slew_steps;
  logic [4:0] next_ctrl;
  logic [7:0] next_slew_steps;

  rmsw_pkg::rmsw_mode_t   mode;
  rmsw_pkg::rmsw_policy_t policy;
  logic                   sel_reg;
  assign mode    = rmsw_pkg::rmsw_mode_t'(ctrl[rmsw_pkg::MODE_LSB +: 2]);
  assign policy  = rmsw_pkg::rmsw_policy_t'(ctrl[rmsw_pkg::POLICY_LSB +: 2]);
  assign sel_reg = ctrl[rmsw_pkg::SEL_BIT];

  // missing-edge monitors: osc, ref a, ref b
  logic [1:0] miss_cnt [3];
  logic [1:0] next_miss_cnt [3];
  logic [2:0] fail;
  logic [2:0] next_fail;
  logic [2:0] mon_edge;
  logic [2:0] mon_fb;
  logic       loop_fb;

  assign loop_fb  = (mode == rmsw_pkg::MODE_LBW) ? lo_edge : up_edge;
  assign mon_edge = {refb_edge, refa_edge, osc_edge};
  assign mon_fb   = {loop_fb, loop_fb, up_edge};

  function automatic logic [1:0] miss_next(input logic [1:0] cnt, input logic edg, input logic fb);
    logic [1:0] r;
    r = cnt;
    if (edg) begin
      r = 2'h0;
    end else if (fb && cnt != rmsw_pkg::MISS_EDGES) begin
      r = cnt + 2'h1;
    end
    return r;
  endfunction

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      next_miss_cnt[i] = miss_next(miss_cnt[i], mon_edge[i], mon_fb[i]);
      next_fail[i]     = (next_miss_cnt[i] == rmsw_pkg::MISS_EDGES);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 3; i++) begin
        miss_cnt[i] <= 2'h0;
      end
      fail <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        miss_cnt[i] <= next_miss_cnt[i];
      end
      fail <= next_fail;
    end
  end

  assign local_osc_fail_flag = fail[0];
  assign ref_a_fail_flag     = fail[1];
  assign ref_b_fail_flag     = fail[2];

  logic valid_a, valid_b;
  assign valid_a = ~fail[1];
  assign valid_b = ~fail[2];

  function automatic logic ref_valid(input logic which, input logic va, input logic vb);
    return which ? vb : va;
  endfunction

  // reserved mode code behaves as synthesizer mode everywhere
  function automatic logic no_select(input rmsw_pkg::rmsw_mode_t m);
    return m == rmsw_pkg::MODE_SYNTH || m == rmsw_pkg::MODE_RSVD;
  endfunction

  // selection state machine
  rmsw_state_t state, next_state;
  logic        next_active;
  logic        hold_q, next_hold;
  logic        is_auto;
  logic        man_sel;
  assign is_auto = policy[1];
  assign man_sel = (policy == rmsw_pkg::POL_MAN_PIN) ? pin_sel : sel_reg;

  always_comb begin
    next_state  = state;
    next_active = active_ref;
    next_hold   = hold_q;
    if (no_select(mode)) begin
      next_state = S_IDLE;
      next_hold  = 1'b0;
    end else begin
      case (state)
        S_IDLE, S_MANUAL: begin
          if (is_auto) begin
            next_state = S_ACQUIRE;
          end else begin
            next_state = S_MANUAL;
            next_active = man_sel;
            next_hold = ~ref_valid(man_sel, valid_a, valid_b);
          end
        end
        S_ACQUIRE: begin
          next_active = sel_reg;
          next_hold   = ~ref_valid(sel_reg, valid_a, valid_b);
          if (!is_auto) begin
            next_state = S_MANUAL;
          end else if (lock_s && ref_valid(sel_reg, valid_a, valid_b)) begin
            next_state = S_RUN;
          end
        end
        S_RUN: begin
          next_hold = 1'b0;
          if (!is_auto) begin
            next_state = S_MANUAL;
          end else if (!ref_valid(active_ref, valid_a, valid_b)) begin
            if (ref_valid(~active_ref, valid_a, valid_b)) begin
              next_active = ~active_ref;
            end else begin
              next_state = S_HOLD;
              next_hold  = 1'b1;
            end
          end else if (active_ref != sel_reg && ref_valid(sel_reg, valid_a, valid_b)
                       && policy == rmsw_pkg::POL_AUTO_REV) begin
            next_active = sel_reg;
          end
        end
        S_HOLD: begin
          next_hold = 1'b1;
          if (!is_auto) begin
            next_state = S_MANUAL;
          end else if (valid_a || valid_b) begin
            next_state  = S_RUN;
            next_hold   = 1'b0;
            next_active = (valid_a && valid_b) ? sel_reg : valid_b;
          end
        end
        default: begin
          next_state = S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= S_IDLE;
      active_ref <= 1'b0;
      hold_q     <= 1'b0;
    end else begin
      state      <= next_state;
      active_ref <= next_active;
      hold_q     <= next_hold;
    end
  end

  assign holdover_out = hold_q;
  assign lock_out     = lock_s & ~hold_q & (state != S_IDLE || no_select(mode));

  // phase slope limiter: steps only stretch a period, never shorten one
  logic [7:0]  slew_left, next_slew_left;
  logic [15:0] gap_cnt, next_gap_cnt;
  logic        switched;
  assign switched = (next_active != active_ref) && !next_hold;

  always_comb begin
    next_slew_left = slew_left;
    next_gap_cnt   = (gap_cnt != 16'h0000) ? gap_cnt - 16'h0001 : 16'h0000;
    phase_extend   = 1'b0;
    if (hold_q) begin
      next_slew_left = 8'h00;
      next_gap_cnt   = 16'h0000;
    end else if (switched) begin
      next_slew_left = slew_steps;
    end else if (slew_left != 8'h00 && gap_cnt == 16'h0000) begin
      phase_extend   = 1'b1;
      next_slew_left = slew_left - 8'h01;
      next_gap_cnt   = 16'(rmsw_pkg::SLEW_GAP_CYC - 1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slew_left <= 8'h00;
      gap_cnt   <= 16'h0000;
    end else begin
      slew_left <= next_slew_left;
      gap_cnt   <= next_gap_cnt;
    end
  end

  assign phase_freeze = hold_q;

  // apb slave, zero wait states
  logic        hit_ctrl, hit_status, hit_slew, mapped, acc;
  logic [31:0] status_word;
  assign acc        = psel & penable;
  assign hit_ctrl   = (paddr == rmsw_pkg::CTRL_OFFS);
  assign hit_status = (paddr == rmsw_pkg::STATUS_OFFS);
  assign hit_slew   = (paddr == rmsw_pkg::SLEW_OFFS);
  assign mapped     = hit_ctrl | hit_status | hit_slew;
  assign pready     = 1'b1;
  assign pslverr    = acc & ~mapped;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[rmsw_pkg::ST_LOCK]    = lock_out;
    status_word[rmsw_pkg::ST_LOSC]    = fail[0];
    status_word[rmsw_pkg::ST_REFA]    = fail[1];
    status_word[rmsw_pkg::ST_REFB]    = fail[2];
    status_word[rmsw_pkg::ST_HOLD]    = hold_q;
    status_word[rmsw_pkg::ST_ACTIVE]  = active_ref;
    status_word[rmsw_pkg::ST_SLEWING] = (slew_left != 8'h00);
  end

  always_comb begin
    next_ctrl       = ctrl;
    next_slew_steps = slew_steps;
    if (acc && pwrite && hit_ctrl) begin
      next_ctrl = pwdata[4:0];
    end
    if (acc && pwrite && hit_slew) begin
      next_slew_steps = pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl       <= rmsw_pkg::CTRL_RST;
      slew_steps <= rmsw_pkg::SLEW_RST;
      prdata     <= 32'h0000_0000;
    end else begin
      ctrl       <= next_ctrl;
      slew_steps <= next_slew_steps;
      if (psel && !penable && !pwrite) begin
        prdata <= hit_ctrl   ? {27'h0000000, ctrl} :
                  hit_status ? status_word :
                  hit_slew   ? {24'h000000, slew_steps} : 32'h0000_0000;
      end
    end
  end

  // checks
  sequence s_three_fb_osc;
    (up_edge && !osc_edge && miss_cnt[0] == 2'h2);
  endsequence

  property p_osc_fail_set;
    @(posedge pclk) disable iff (!presetn) s_three_fb_osc |=> local_osc_fail_flag;
  endproperty
  a_osc_fail_set: assert property (p_osc_fail_set) else $error("osc alarm not set");

  property p_osc_fail_clr;
    @(posedge pclk) disable iff (!presetn) osc_edge |=> !local_osc_fail_flag;
  endproperty
  a_osc_fail_clr: assert property (p_osc_fail_clr) else $error("osc alarm not cleared");

  property p_refa_set;
    @(posedge pclk) disable iff (!presetn)
      (loop_fb && !refa_edge && miss_cnt[1] == 2'h2) |=> ref_a_fail_flag;
  endproperty
  a_refa_set: assert property (p_refa_set) else $error("ref a alarm not set");

  property p_refb_clr;
    @(posedge pclk) disable iff (!presetn) refb_edge |=> !ref_b_fail_flag;
  endproperty
  a_refb_clr: assert property (p_refb_clr) else $error("ref b alarm not cleared");

  property p_lock_needs_lock;
    @(posedge pclk) disable iff (!presetn) lock_out |-> lock_s;
  endproperty
  a_lock_needs_lock: assert property (p_lock_needs_lock) else $error("lock shown without lock");

  property p_auto_hold_both;
    @(posedge pclk) disable iff (!presetn) (state == S_HOLD) |-> $past(!valid_a && !valid_b);
  endproperty
  a_auto_hold_both: assert property (p_auto_hold_both) else $error("hold with a valid reference");

  property p_manual_follow;
    @(posedge pclk) disable iff (!presetn)
      (state == S_MANUAL && next_state == S_MANUAL) |=> active_ref == $past(man_sel);
  endproperty
  a_manual_follow: assert property (p_manual_follow) else $error("manual choice not taken");

  property p_hold_freeze;
    @(posedge pclk) disable iff (!presetn) hold_q |-> !phase_extend ##1 (slew_left == 8'h00);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze) else $error("phase moved in holdover");

  property p_step_gap;
    @(posedge pclk) disable iff (!presetn) phase_extend |=> !phase_extend [*8];
  endproperty
  a_step_gap: assert property (p_step_gap) else $error("phase steps too close");

  property p_synth_idle;
    @(posedge pclk) disable iff (!presetn)
      (mode == rmsw_pkg::MODE_SYNTH) |=> $stable(active_ref) || $past(mode) != rmsw_pkg::MODE_SYNTH;
  endproperty
  a_synth_idle: assert property (p_synth_idle) else $error("selection moved in synth mode");
endmodule

// ===== bench/rmsw_ref_src.sv
`timescale 1ns/100ps
module rmsw_ref_src (
  input  wire logic       pclk,         // bench clock
  input  wire logic [4:0] en,           // osc, ref a, ref b, upper fb, lower fb
  output logic            local_osc_in, // local oscillator
  output logic            ref_in_a,     // reference a
  output logic            ref_in_b,     // reference b
  output logic            upper_fb_in,  // upper loop feedback
  output logic            lower_fb_in   // lower loop feedback
);
  logic [2:0] ph = 3'h0;
  logic [2:0] ph_ref;
  always @(posedge pclk) begin
    ph <= ph + 3'h1;
  end
  // refs lead feedback by two cycles so both never rise in the same cycle
  assign ph_ref = ph + 3'h2;
  assign ref_in_a = en[1] & ph_ref[2];
  assign ref_in_b = en[2] & ph_ref[2];
  // a stopped source stands still, which is the fault being modelled
  assign local_osc_in = en[0] & ph_ref[2];
  assign upper_fb_in  = en[3] & ph[2];
  assign lower_fb_in  = en[4] & ph[2];
endmodule

// ===== bench/ref_monitor_switchover_bench.sv
`timescale 1ns/100ps
module ref_monitor_switchover_bench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        local_osc_in;
  logic        ref_in_a;
  logic        ref_in_b;
  logic        upper_fb_in;
  logic        lower_fb_in;
  logic        freq_lock_in = 1'b0;
  logic        ref_sel_pin = 1'b0;
  logic        lock_out;
  logic        holdover_out;
  logic        active_ref;
  logic        local_osc_fail_flag;
  logic        ref_a_fail_flag;
  logic        ref_b_fail_flag;
  logic        phase_extend;
  logic        phase_freeze;
  logic [4:0]  en = 5'h1F;
  logic [31:0] rd;
  logic        err;
  int          n_fail = 0;
  int          checked = 0;
  int          n_ext = 0;
  int          cyc = 0;

  rmsw_core rmsw_core_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .local_osc_in, .ref_in_a, .ref_in_b, .upper_fb_in, .lower_fb_in, .freq_lock_in, .ref_sel_pin,
    .lock_out, .holdover_out, .active_ref, .local_osc_fail_flag, .ref_a_fail_flag, .ref_b_fail_flag,
    .phase_extend, .phase_freeze);
  rmsw_ref_src rmsw_ref_src_inst (.pclk, .en, .local_osc_in, .ref_in_a, .ref_in_b, .upper_fb_in, .lower_fb_in);

  initial begin
    forever #5 pclk = ~pclk;
  end

  task automatic final_report();
    if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // stretch pulses are counted continuously; a hang is cut short here
  always @(posedge pclk) begin
    cyc++;
    if (phase_extend === 1'b1) n_ext++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      n_fail++;
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task automatic drv(input logic [4:0] e, input logic lk, input logic pin);
    @(posedge pclk);
    en <= e;
    freq_lock_in <= lk;
    ref_sel_pin <= pin;
  endtask

  task automatic rst();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] p, input logic s);
    return {27'h0, s, p, m};
  endfunction

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, rmsw_pkg::CTRL_OFFS, 32'h0);
    chk("ctrl reset", {27'h0, rmsw_pkg::CTRL_RST}, rd);
    chk("ready", 32'h1, pready);
    apb(1'b0, rmsw_pkg::SLEW_OFFS, 32'h0);
    chk("slew reset", {24'h0, rmsw_pkg::SLEW_RST}, rd);
    apb(1'b1, rmsw_pkg::STATUS_OFFS, 32'hFFFFFFFF);
    wt(40);
    apb(1'b0, rmsw_pkg::STATUS_OFFS, 32'h0);
    chk("status idle", 32'h0, rd);
    apb(1'b1, 8'h0C, 32'hFFFFFFFF);
    chk("write error", 32'h1, err);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped data", 32'h0, rd);
    chk("read error", 32'h1, err);
    // automatic start: preferred b, unlocked
    apb(1'b1, rmsw_pkg::SLEW_OFFS, 32'h2);
    apb(1'b1, rmsw_pkg::CTRL_OFFS, ctl(rmsw_pkg::MODE_HBW, rmsw_pkg::POL_AUTO_REV, 1'b1));
    wt(60);
    chk("auto both valid", 32'h1, active_ref);
    drv(5'h1B, 1'b0, 1'b0);
    wt(60);
    chk("acquire stays", 32'h1, active_ref);
    chk("ref b alarm", 32'h1, ref_b_fail_flag);
    drv(5'h1F, 1'b1, 1'b0);
    wt(60);
    chk("lock pin", 32'h1, lock_out);
    chk("ref b clear", 32'h0, ref_b_fail_flag);
    wt(400);
    n_ext = 0;
    drv(5'h1B, 1'b1, 1'b1);
    wt(60);
    chk("failover", 32'h0, active_ref);
    chk("no holdover", 32'h0, holdover_out);
    wt(340);
    chk("stretch steps", 32'h2, n_ext);
    chk("pin ignored", 32'h0, active_ref);
    drv(5'h1F, 1'b1, 1'b1);
    wt(60);
    chk("revert", 32'h1, active_ref);
    drv(5'h1F, 1'b0, 1'b1);
    wt(20);
    chk("lock lost", 32'h0, lock_out);
    wt(400);
    apb(1'b1, rmsw_pkg::CTRL_OFFS, ctl(rmsw_pkg::MODE_HBW, rmsw_pkg::POL_AUTO_NREV, 1'b1));
    drv(5'h1F, 1'b1, 1'b0);
    wt(60);
    chk("nonrev preferred", 32'h1, active_ref);
    wt(400);
    drv(5'h1B, 1'b1, 1'b0);
    wt(60);
    chk("nonrev failover", 32'h0, active_ref);
    wt(400);
    drv(5'h1F, 1'b1, 1'b0);
    wt(60);
    chk("nonrev stays", 32'h0, active_ref);
    drv(5'h19, 1'b1, 1'b0);
    wt(60);
    chk("both lost", 32'h1, holdover_out);
    chk("freeze", 32'h1, phase_freeze);
    chk("lock in holdover", 32'h0, lock_out);
    n_ext = 0;
    wt(300);
    chk("no steps", 32'h0, n_ext);
    apb(1'b0, rmsw_pkg::STATUS_OFFS, 32'h0);
    chk("status alarms", 32'h1C, rd);
    drv(5'h1D, 1'b1, 1'b0);
    wt(60);
    chk("first back", 32'h1, active_ref);
    chk("holdover left", 32'h0, holdover_out);
    wt(400);
    apb(1'b1, rmsw_pkg::CTRL_OFFS, ctl(rmsw_pkg::MODE_HBW, rmsw_pkg::POL_MAN_REG, 1'b1));
    drv(5'h1F, 1'b1, 1'b0);
    wt(60);
    chk("manual reg", 32'h1, active_ref);
    drv(5'h1B, 1'b1, 1'b0);
    wt(60);
    chk("manual holdover", 32'h1, holdover_out);
    chk("no self switch", 32'h1, active_ref);
    drv(5'h1F, 1'b1, 1'b0);
    wt(60);
    chk("manual recover", 32'h0, holdover_out);
    apb(1'b1, rmsw_pkg::CTRL_OFFS, ctl(rmsw_pkg::MODE_HBW, rmsw_pkg::POL_MAN_PIN, 1'b1));
    wt(60);
    chk("manual pin a", 32'h0, active_ref);
    drv(5'h1F, 1'b1, 1'b1);
    wt(60);
    chk("manual pin b", 32'h1, active_ref);
    wt(400);
    apb(1'b1, rmsw_pkg::CTRL_OFFS, ctl(rmsw_pkg::MODE_SYNTH, rmsw_pkg::POL_MAN_PIN, 1'b0));
    drv(5'h1C, 1'b1, 1'b0);
    wt(60);
    chk("synth holds", 32'h1, active_ref);
    chk("osc alarm", 32'h1, local_osc_fail_flag);
    chk("ref a alarm synth", 32'h1, ref_a_fail_flag);
    drv(5'h1F, 1'b1, 1'b0);
    wt(20);
    chk("osc clear", 32'h0, local_osc_fail_flag);
    apb(1'b1, rmsw_pkg::CTRL_OFFS, ctl(rmsw_pkg::MODE_RSVD, rmsw_pkg::POL_MAN_PIN, 1'b0));
    wt(20);
    chk("reserved holds", 32'h1, active_ref);
    chk("reserved lock", 32'h1, lock_out);
    apb(1'b1, rmsw_pkg::CTRL_OFFS, ctl(rmsw_pkg::MODE_LBW, rmsw_pkg::POL_MAN_REG, 1'b0));
    drv(5'h0D, 1'b1, 1'b0);
    wt(60);
    chk("lower fb used", 32'h0, ref_a_fail_flag);
    drv(5'h1D, 1'b1, 1'b0);
    wt(60);
    chk("ref a alarm", 32'h1, ref_a_fail_flag);
    drv(5'h1F, 1'b1, 1'b0);
    wt(20);
    chk("ref a clear", 32'h0, ref_a_fail_flag);
    rst();
    wt(2);
    chk("reset active", 32'h0, active_ref);
    chk("reset holdover", 32'h0, holdover_out);
    final_report();
  end
endmodule
